// *** host_model.sv ***
// Behavioural host driving the three-wire serial link
`timescale 1ns/1ps
module host_model (
    output logic sclk_o,
    output logic csn_o,
    output logic sd_o
);
    // Idle: deselected, clock parked low; chip select starts low and
    // rises at 1 ns so the link counter sees a definite clearing edge
    initial begin
        sclk_o = 1'b0;
        csn_o  = 1'b0;
        sd_o   = 1'b1;
        #1 csn_o = 1'b1;
    end
    // Select a setup time ahead of the first clock edge
    task automatic cs_low();
        csn_o = 1'b0;
        #100;
    endtask
    // 7.5 ns clock high pulse per bit, bits 135 ns apart so events never overrun
    task automatic send_bits(input logic [7:0] v, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            sd_o = v[i];
            #60 sclk_o = 1'b1;
            #7.5 sclk_o = 1'b0;
            #67.5;
        end
    endtask
    // Released data shows the inverse so a stale level cannot pass
    task automatic cs_high();
        #60 csn_o = 1'b1;
        sd_o = ~sd_o;
        #200;
    endtask
    // Wiggle clock and data while deselected
    task automatic noise(input int n);
        repeat (n) begin
            #20 sclk_o = ~sclk_o;
            sd_o = ~sd_o;
        end
        sclk_o = 1'b0;
    endtask
endmodule // host_model

// *** nib_ram.sv ***
// Nibble-wide RAM with one write port and a registered read port
`timescale 1ns/1ps
module nib_ram
    import tw_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              ce_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] waddr_i,
    input  wire logic [NIB_W-1:0]  wdata_i,
    input  wire logic [ADDR_W-1:0] raddr_i,
    output logic      [NIB_W-1:0]  rdata_o
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Contents are not cleared by reset, software must fill them
    logic [NIB_W-1:0] mem [RAM_DEPTH];

    // Write port, one nibble per enabled cycle
    always_ff @(posedge mclk_i) begin
        if (ce_i && we_i && (waddr_i <= ADDR_LAST)) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // Registered read; out of range reads give zero
    always_ff @(posedge mclk_i) begin
        if (ce_i) begin
            rdata_o <= (raddr_i <= ADDR_LAST) ? mem[raddr_i] : NIB_RESET;
        end
    end

endmodule // nib_ram

// *** tw_pkg.sv ***
// Shared constants and types for the three-wire command and RAM write port
package tw_pkg;

    // ------------------------------------------------------------
    // Word framing
    // ------------------------------------------------------------
    localparam int          WORD_BITS     = 8;
    localparam logic [3:0]  CNT_RESET     = 4'h0;
    localparam logic [3:0]  CNT_FIRST     = 4'h1;
    localparam logic [3:0]  CNT_NIBBLE    = 4'h4;
    localparam logic [3:0]  CNT_WORD      = 4'h8;
    localparam int          FLAG_BIT      = 7;

    // ------------------------------------------------------------
    // Display and blink RAM geometry
    // ------------------------------------------------------------
    localparam int          RAM_DEPTH     = 28;
    localparam int          ADDR_W        = 5;
    localparam int          NIB_W         = 4;
    localparam logic [4:0]  ADDR_FIRST    = 5'h00;
    localparam logic [4:0]  ADDR_LAST     = 5'h1b;
    localparam logic [3:0]  NIB_RESET     = 4'h0;

    // ------------------------------------------------------------
    // Command codes known for this port, and output buffer constants
    // ------------------------------------------------------------
    localparam logic [7:0]  DISPLAY_RAM_WRITE_CMD   = 8'ha0;
    localparam logic [7:0]  DISPLAY_ADDRESS_SET_CMD = 8'h83;
    localparam logic [7:0]  CMD_RESET               = 8'h00;
    localparam int          BUF_DEPTH               = 2;
    localparam logic [1:0]  BUF_CNT_RESET           = 2'h0;

    // Decoding mode of the port
    typedef enum logic [1:0] {
        MODE_CMD,
        MODE_DISP,
        MODE_BLINK,
        MODE_GPO
    } port_mode_t;

    // Kind of word handed downstream
    typedef enum logic [1:0] {
        KIND_CMD,
        KIND_PARAM,
        KIND_GPO
    } word_kind_t;

    // Event handed from the link domain
    typedef struct packed {
        logic       first;
        logic       half;
        logic [7:0] data;
    } link_word_t;

    // Decoded word for the other command decoders
    typedef struct packed {
        word_kind_t kind;
        logic [7:0] data;
    } out_word_t;

    // One nibble write into display or blink RAM
    typedef struct packed {
        logic       disp;
        logic       blink;
        logic [4:0] addr;
        logic [3:0] nib;
    } ram_wr_t;

endpackage

// *** tw_port.sv ***
// Receive side of the three-wire serial command and RAM write port
`timescale 1ns/1ps
// Contract
// R1: Chip select high clears the serial bit counter.
// R2: Serial clock and data count only while chip select is low.
// R3: Host sends each word MSB first, flag bit then D6 to D0.
// R4: Serial data is sampled on every serial clock rising edge.
// R5: Eighth falling edge moves shifted bits into the parallel word.
// R6: Chip select rising before eight bits discards the partial word.
// R7: Display write, blink write, port set commands enter RAM data mode.
// R8: Chip select high then low leaves RAM data mode.
// R9: Data after display write go to display RAM, after blink write blink RAM.
// R10: Clock and data levels are ignored while chip select is high.
// R11: Display RAM holds 28 nibbles.
// R12: Writes start at the set address, advancing every four bits.
// R13: Address goes 1Ah, dummy 1Bh, then wraps to 00h.
// R14: Addresses of pins used as outputs stay in sequence as dummies.
// R15: RAM commits per nibble; an unfinished nibble is dropped.
// R16: Word MSB one marks command, zero marks parameter or data.
// R17: Address set command loads the display RAM write pointer.
// R18: Upper nibble goes to current address, lower to the next.
// R19: Outside data mode a flag-clear word is the last command's parameter.
module tw_port
    import tw_pkg::*;
#(
    parameter logic [7:0] BLINK_RAM_WRITE_CMD   = 8'ha1,
    parameter logic [7:0] OUTPUT_PORT_SET_CMD   = 8'ha2,
    parameter logic [7:0] BLINK_ADDRESS_SET_CMD = 8'h85
)
(
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    input  wire logic              ce_i,
    input  wire logic              serial_clock_i,
    input  wire logic              chip_select_n_i,
    input  wire logic              serial_data_in_i,
    output out_word_t              word_o,
    output logic                   word_valid_o,
    input  wire logic              word_ready_i,
    output ram_wr_t                ram_write_o,
    output logic                   ram_mode_o,
    output logic                   overrun_o,
    input  wire logic [ADDR_W-1:0] disp_rd_addr_i,
    output logic      [NIB_W-1:0]  disp_rd_data_o,
    input  wire logic [ADDR_W-1:0] blink_rd_addr_i,
    output logic      [NIB_W-1:0]  blink_rd_data_o
);

    // ------------------------------------------------------------
    // Link domain: serial clock
    // ------------------------------------------------------------
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic        first_pend;
    logic        ev_toggle;
    link_word_t  ev_word;
    logic        fire;

    // Bit counter, held clear by chip select high
    // The clear is asynchronous, so a cut word needs no further serial clock
    always_ff @(posedge serial_clock_i or posedge chip_select_n_i) begin
        if (chip_select_n_i) begin
            bit_cnt <= CNT_RESET; // R1 R10
        end else if (bit_cnt == CNT_WORD) begin
            bit_cnt <= CNT_FIRST;
        end else begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    // Shift in, MSB first; the flag bit ends up in bit 7
    always_ff @(posedge serial_clock_i) begin
        if (!chip_select_n_i) begin
            shreg <= {shreg[6:0], serial_data_in_i}; // R4 R2 R3
        end
    end

    // A nibble or a whole word is complete on this falling edge
    assign fire = !chip_select_n_i &&
                  ((bit_cnt == CNT_NIBBLE) || (bit_cnt == CNT_WORD)); // R15 R6

    // Marks the first event after chip select fell
    always_ff @(negedge serial_clock_i or posedge chip_select_n_i) begin
        if (chip_select_n_i) begin
            first_pend <= 1'b1; // R8
        end else if (fire) begin
            first_pend <= 1'b0;
        end
    end

    // Parallel word captured on the falling edge; it stays put for
    // at least four serial clocks, long enough for the crossing
    always_ff @(negedge serial_clock_i) begin
        if (fire) begin
            ev_word.first <= first_pend;
            ev_word.half  <= (bit_cnt == CNT_NIBBLE);
            ev_word.data  <= shreg; // R5
        end
    end

    // Event toggle; a chip select rise before it cancels the event
    always_ff @(negedge serial_clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ev_toggle <= 1'b0;
        end else if (fire) begin
            ev_toggle <= ~ev_toggle; // R6 R15
        end
    end

    // ------------------------------------------------------------
    // Crossing into the main clock
    // ------------------------------------------------------------
    // Only the event toggle is synchronised; the word itself stands still
    // on the link side for four serial clocks, so it is copied without flops
    logic        tog_s1;
    logic        tog_s2;
    logic        tog_seen;
    logic        ev_new;
    logic        pend_valid;
    link_word_t  pend;
    logic        take;

    // Two-stage synchroniser for the event toggle
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
        end else if (ce_i) begin
            tog_s1 <= ev_toggle;
            tog_s2 <= tog_s1;
        end
    end

    // A toggle that differs from the last one seen marks a new event
    assign ev_new = tog_s2 ^ tog_seen;

    // Pending event slot; a new event wins over the consume
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tog_seen   <= 1'b0;
            pend_valid <= 1'b0;
            pend       <= '0;
        end else if (ce_i) begin
            if (ev_new) begin
                tog_seen   <= tog_s2;
                pend_valid <= 1'b1;
                pend       <= ev_word;
            end else if (take) begin
                pend_valid <= 1'b0;
            end
        end
    end

    // Overrun: serial link cannot be stalled, so a word is lost;
    // a one-cycle flag in enabled cycles, frozen like the rest when
    // the enable is low
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            overrun_o <= 1'b0;
        end else if (ce_i) begin
            overrun_o <= ev_new && pend_valid && !take;
        end
    end

    // ------------------------------------------------------------
    // Decoder
    // ------------------------------------------------------------
    // One pending event is taken per enabled cycle; RAM nibbles never
    // wait, only words bound for the buffer can stall the decoder
    port_mode_t       mode;
    port_mode_t       eff_mode;
    port_mode_t       next_mode;
    logic [7:0]       last_cmd;
    logic [7:0]       next_last_cmd;
    logic [4:0]       disp_addr;
    logic [4:0]       blink_addr;
    logic             need_out;
    logic             buf_in_ready;
    out_word_t        push_word;
    logic             push;

    // Step the nibble address, keeping dummy and port addresses
    // Pins used as outputs keep their slot, so no address is skipped
    function automatic logic [4:0] step_addr(input logic [4:0] a);
        step_addr = (a >= ADDR_LAST) ? ADDR_FIRST : a + 5'h01; // R13 R14 R12
    endfunction

    // First event of a frame starts in command mode
    // Nibble events never reach the buffer, only whole words do
    always_comb begin
        eff_mode = pend.first ? MODE_CMD : mode; // R8
        need_out = !pend.half && ((eff_mode == MODE_CMD) || (eff_mode == MODE_GPO));
        take     = pend_valid && (!need_out || buf_in_ready);
        push     = take && need_out;
    end

    // Mode and command tracking
    always_comb begin
        next_mode     = eff_mode;
        next_last_cmd = last_cmd;
        push_word     = '{kind: KIND_GPO, data: pend.data};
        if (eff_mode == MODE_CMD) begin
            if (pend.data[FLAG_BIT]) begin
                push_word.kind = KIND_CMD; // R16
                next_last_cmd  = pend.data;
                if (pend.data == DISPLAY_RAM_WRITE_CMD) begin
                    next_mode = MODE_DISP; // R7
                end else if (pend.data == BLINK_RAM_WRITE_CMD) begin
                    next_mode = MODE_BLINK; // R7
                end else if (pend.data == OUTPUT_PORT_SET_CMD) begin
                    next_mode = MODE_GPO; // R7
                end
            end else begin
                push_word.kind = KIND_PARAM; // R19
            end
        end
        if (pend.half) begin
            next_mode     = (eff_mode == MODE_CMD) ? mode : eff_mode;
            next_last_cmd = last_cmd;
        end
    end

    // Mode state; cleared by reset to command decoding
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            mode     <= MODE_CMD;
            last_cmd <= CMD_RESET;
        end else if (ce_i && take) begin
            mode     <= pend.half && pend.first ? MODE_CMD : next_mode;
            last_cmd <= next_last_cmd;
        end
    end

    // Data mode shows as soon as the mode register leaves command decoding
    assign ram_mode_o = (mode != MODE_CMD);

    // Address pointers: loaded by parameters, stepped per nibble
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            disp_addr  <= ADDR_FIRST;
            blink_addr <= ADDR_FIRST;
        end else if (ce_i && take) begin
            if (eff_mode == MODE_CMD && !pend.half && !pend.data[FLAG_BIT]) begin
                if (last_cmd == DISPLAY_ADDRESS_SET_CMD) begin
                    disp_addr <= pend.data[4:0]; // R17 R12
                end
                if (last_cmd == BLINK_ADDRESS_SET_CMD) begin
                    blink_addr <= pend.data[4:0];
                end
            end
            if (eff_mode == MODE_DISP) begin
                disp_addr <= step_addr(disp_addr); // R12 R13
            end
            if (eff_mode == MODE_BLINK) begin
                blink_addr <= step_addr(blink_addr); // R12 R13
            end
        end
    end

    // Nibble write strobe; bits 3:0 hold the last four bits
    // shifted, so the upper nibble lands first, then the lower
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ram_write_o <= '0;
        end else if (ce_i) begin
            ram_write_o.disp  <= take && (eff_mode == MODE_DISP); // R9 R15
            ram_write_o.blink <= take && (eff_mode == MODE_BLINK); // R9
            ram_write_o.addr  <= (eff_mode == MODE_BLINK) ? blink_addr : disp_addr;
            ram_write_o.nib   <= pend.data[3:0]; // R18
        end
    end

    // ------------------------------------------------------------
    // Display and blink RAM
    // ------------------------------------------------------------
    // Display RAM: 28 nibbles, the last one a dummy that nothing shows
    nib_ram u_disp_ram (
        .mclk_i  (mclk_i),
        .ce_i    (ce_i),
        .we_i    (ram_write_o.disp),
        .waddr_i (ram_write_o.addr),
        .wdata_i (ram_write_o.nib),
        .raddr_i (disp_rd_addr_i),
        .rdata_o (disp_rd_data_o)
    ); // R11

    // Blink RAM shares the write record; only its enable differs
    nib_ram u_blink_ram (
        .mclk_i  (mclk_i),
        .ce_i    (ce_i),
        .we_i    (ram_write_o.blink),
        .waddr_i (ram_write_o.addr),
        .wdata_i (ram_write_o.nib),
        .raddr_i (blink_rd_addr_i),
        .rdata_o (blink_rd_data_o)
    );

    // ------------------------------------------------------------
    // Two-entry output buffer
    // ------------------------------------------------------------
    // Two entries let the decoder push while the reader stalls on one word
    out_word_t   buf_mem [BUF_DEPTH];
    logic        wr_ptr;
    logic        rd_ptr;
    logic [1:0]  buf_cnt;
    logic        pop;

    // A full buffer holds the pending event, stalling the decoder
    assign buf_in_ready = (buf_cnt != 2'h2);
    assign word_valid_o = (buf_cnt != BUF_CNT_RESET);
    assign pop          = word_valid_o && word_ready_i && ce_i;
    assign word_o       = buf_mem[rd_ptr];

    // Entry storage
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
        end else if (ce_i && push) begin
            buf_mem[wr_ptr] <= push_word;
        end
    end

    // Pointers and fill count
    // The count moves only when push and pop differ
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wr_ptr  <= 1'b0;
            rd_ptr  <= 1'b0;
            buf_cnt <= BUF_CNT_RESET;
        end else if (ce_i) begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            case ({push, pop})
                2'b10:   buf_cnt <= buf_cnt + 2'h1;
                2'b01:   buf_cnt <= buf_cnt - 2'h1;
                default: buf_cnt <= buf_cnt;
            endcase
        end
    end

endmodule // tw_port

// *** tw_port_sva.sv ***
// Assertion checker for the three-wire command and RAM write port
`timescale 1ns/1ps
module tw_port_sva
    import tw_pkg::*;
(
    input  wire logic      mclk_i,
    input  wire logic      rst_n_i,
    input  wire logic      ce_i,
    input  wire logic      chip_select_n_i,
    input  wire out_word_t word_o,
    input  wire logic      word_valid_o,
    input  wire logic      word_ready_i,
    input  wire ram_wr_t   ram_write_o,
    input  wire logic      ram_mode_o
);
    logic [4:0] last_addr;
    logic       have_last;

    // Forget the last address when RAM mode ends, so a new start is free
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || !ram_mode_o) begin
            have_last <= 1'b0;
        end else if (ram_write_o.disp) begin
            have_last <= 1'b1;
        end
    end

    // Last display address written
    always_ff @(posedge mclk_i) begin
        if (ram_write_o.disp) begin
            last_addr <= ram_write_o.addr;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // ------------------------------------------------------------
    // Port properties
    // ------------------------------------------------------------
    a_one_ram_only: assert property (ram_write_o.disp |-> !ram_write_o.blink)
        else $error("display and blink strobes together");
    a_write_in_mode: assert property (ram_write_o.disp || ram_write_o.blink |-> ram_mode_o)
        else $error("RAM write outside RAM data mode");
    a_addr_in_range: assert property (ram_write_o.disp || ram_write_o.blink |-> ram_write_o.addr <= ADDR_LAST)
        else $error("RAM write beyond last location");
    a_addr_advance: assert property (ram_write_o.disp && have_last |->
        ram_write_o.addr == ((last_addr == ADDR_LAST) ? ADDR_FIRST : last_addr + 5'h01))
        else $error("display address did not step by one");
    a_idle_no_write: assert property (chip_select_n_i [*6] |=> !(ram_write_o.disp || ram_write_o.blink))
        else $error("RAM write while deselected");
    a_idle_mode: assert property (chip_select_n_i [*6] |=> $stable(ram_mode_o))
        else $error("mode changed while deselected");
    a_word_held: assert property (word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_o))
        else $error("buffered word lost during stall");
    a_freeze_valid: assert property (!ce_i |=> $stable(word_valid_o))
        else $error("buffer moved with clock enable low");
endmodule // tw_port_sva

bind tw_port tw_port_sva i_sva (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .chip_select_n_i(chip_select_n_i), .word_o(word_o), .word_valid_o(word_valid_o),
    .word_ready_i(word_ready_i), .ram_write_o(ram_write_o), .ram_mode_o(ram_mode_o));

// *** tw_port_tb.sv ***
// Self-checking testbench for the three-wire command and RAM write port
`timescale 1ns/1ps
module tw_port_tb
    import tw_pkg::*;
;
    logic              mclk_i;
    logic              rst_n_i;
    logic              ce_i;
    logic              word_ready_i;
    logic              stall;
    logic [4:0]        disp_rd_addr_i;
    logic [4:0]        blink_rd_addr_i;
    wire               sclk;
    wire               csn;
    wire               sdat;
    out_word_t         word_o;
    logic              word_valid_o;
    ram_wr_t           ram_write_o;
    logic              ram_mode_o;
    logic              overrun_o;
    logic [3:0]        disp_rd_data_o;
    logic [3:0]        blink_rd_data_o;
    int                fail_count;
    int                samples_checked;
    int                mode;
    logic [31:0]       seed;
    logic [31:0]       rnd;
    logic [7:0]        last_cmd;
    logic [4:0]        ptr[2];
    logic [3:0]        disp_img[28];
    logic [3:0]        blink_img[28];
    out_word_t         exp_words[$];
    ram_wr_t           exp_wrs[$];

    tw_port i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .serial_clock_i(sclk),
        .chip_select_n_i(csn), .serial_data_in_i(sdat), .word_o(word_o), .word_valid_o(word_valid_o),
        .word_ready_i(word_ready_i), .ram_write_o(ram_write_o), .ram_mode_o(ram_mode_o), .overrun_o(overrun_o),
        .disp_rd_addr_i(disp_rd_addr_i), .disp_rd_data_o(disp_rd_data_o),
        .blink_rd_addr_i(blink_rd_addr_i), .blink_rd_data_o(blink_rd_data_o));
    host_model i_host (.sclk_o(sclk), .csn_o(csn), .sd_o(sdat));

    // 10 MHz main clock
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    task automatic model_nib(input logic [3:0] n);
        int k;
        k = mode - 1;
        exp_wrs.push_back('{disp: mode == 1, blink: mode == 2, addr: ptr[k], nib: n});
        if (mode == 1) disp_img[ptr[k]] = n;
        else blink_img[ptr[k]] = n;
        ptr[k] = (ptr[k] == ADDR_LAST) ? ADDR_FIRST : ptr[k] + 5'h01;
    endtask

    task automatic send(input logic [7:0] b);
        if (mode == 1 || mode == 2) begin
            model_nib(b[7:4]);
            model_nib(b[3:0]);
        end else if (mode == 3) begin
            exp_words.push_back('{KIND_GPO, b});
        end else if (b[FLAG_BIT]) begin
            exp_words.push_back('{KIND_CMD, b});
            last_cmd = b;
            mode = (b == DISPLAY_RAM_WRITE_CMD) ? 1 : (b == 8'ha1) ? 2 : (b == 8'ha2) ? 3 : 0;
        end else begin
            exp_words.push_back('{KIND_PARAM, b});
            if (last_cmd == DISPLAY_ADDRESS_SET_CMD) ptr[0] = b[4:0];
            if (last_cmd == 8'h85) ptr[1] = b[4:0];
        end
        i_host.send_bits(b, 8);
    endtask

    // Deselect, then wait bounded for every expected result, then settle
    task automatic close();
        int n;
        i_host.cs_high();
        for (n = 0; n < 400 && exp_words.size() + exp_wrs.size() != 0; n++) @(posedge mclk_i);
        repeat (10) @(posedge mclk_i);
        check(16'(exp_words.size() + exp_wrs.size()), 16'h0000);
        check(16'(ram_mode_o), 16'(mode != 0));
        if (n >= 400) report_and_stop();
    endtask

    // Compare every strobe and every accepted word with the model
    always @(posedge mclk_i) begin
        seed <= xs(seed);
        word_ready_i <= !stall && seed[0];
        if (rst_n_i && (ram_write_o.disp || ram_write_o.blink))
            check(16'(ram_write_o), exp_wrs.size() ? 16'(exp_wrs.pop_front()) : 16'hffff);
        if (rst_n_i && word_valid_o === 1'b1 && word_ready_i && ce_i)
            check(16'(word_o), exp_words.size() ? 16'(exp_words.pop_front()) : 16'hffff);
        // Bits are spaced so that no word is ever lost
        if (rst_n_i) check(16'(overrun_o), 16'h0000);
    end

    initial begin
        rst_n_i = 1'b1;
        ce_i = 1'b1;
        word_ready_i = 1'b0;
        stall = 1'b0;
        disp_rd_addr_i = 5'h00;
        blink_rd_addr_i = 5'h00;
        fail_count = 0;
        samples_checked = 0;
        mode = 0;
        seed = 32'heb5cbe3e;
        rnd = 32'heb5cbe3e;
        foreach (disp_img[i]) disp_img[i] = 4'hx;
        foreach (blink_img[i]) blink_img[i] = 4'hx;
        // A definite falling edge at 1 ns clears the link-side toggle
        #1 rst_n_i = 1'b0;
        repeat (4) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        // Random start, then a start just before the wrap; every RAM mode command
        for (int t = 0; t < 4; t++) begin
            rnd = xs(rnd);
            i_host.cs_low();
            mode = 0;
            send(t < 3 ? 8'h83 : 8'h85);
            send(t == 1 ? 8'h1a : 8'(rnd % 28));
            send(t < 2 ? 8'ha0 : t == 2 ? 8'ha2 : 8'ha1);
            send(rnd[15:8]);
            send(rnd[23:16]);
            close();
            $display("test ram stream %0d done", t);
        end
        // Partial word in command mode, then a clean word after counter clear
        i_host.cs_low();
        i_host.send_bits(8'h83, 5);
        i_host.cs_high();
        i_host.noise(6);
        i_host.cs_low();
        mode = 0;
        send(8'h83);
        send(8'h02);
        send(8'ha0);
        send(8'h5a);
        i_host.send_bits(8'hc3, 6);
        model_nib(4'hc);
        close();
        $display("test partial words done");
        // Stalled receiver keeps both words; clock enable freeze while chip select is still low
        stall = 1'b1;
        i_host.cs_low();
        mode = 0;
        send(8'h81);
        send(8'h05);
        repeat (10) @(posedge mclk_i);
        check(16'(word_valid_o), 16'h0001);
        // Enable low while ready is offered: both words must stay put
        ce_i <= 1'b0;
        stall = 1'b0;
        repeat (5) @(posedge mclk_i);
        check(16'(word_valid_o), 16'h0001);
        ce_i <= 1'b1;
        close();
        $display("test stall done");
        // Read back both RAMs
        for (int a = 0; a < RAM_DEPTH; a++) begin
            @(posedge mclk_i);
            disp_rd_addr_i <= 5'(a);
            blink_rd_addr_i <= 5'(a);
            @(posedge mclk_i);
            @(negedge mclk_i);
            if (disp_img[a] !== 4'hx) check(16'(disp_rd_data_o), 16'(disp_img[a]));
            if (blink_img[a] !== 4'hx) check(16'(blink_rd_data_o), 16'(blink_img[a]));
        end
        $display("test readback done");
        report_and_stop();
    end
endmodule // tw_port_tb
